// >>> logic/bbiow_regs.sv
// Bridge subordinate bus, I/O window and secondary status registers on APB
//
// How it works
// - Subordinate bus number, byte 2 at 0x18, read-write, resets to zero.
// - Secondary latency timer byte at 0x18 always reads zero, ignores writes.
// - Both I/O addressing nibbles read 1h, advertising 32-bit I/O decode.
// - I/O base field gives window bottom bits 15:12; low bits zero.
// - I/O limit field gives window top bits 15:12; low bits all ones.
// - Window address bits 31:16 come from the separate upper registers.
// - Status bits 21, 23, 26:25 and reserved bits read zero.
// - Parity status bit sets on secondary parity error only when enabled.
// - Completer-abort-sent bit sets when port completes with that status.
// - Completer-abort-received bit sets on such completion received.
// - Unsupported-request-received bit sets on such completion received.
// - System error bit sets on error message while system error enabled.
// - Poisoned bit sets whenever secondary side receives a poisoned packet.
module bbiow_regs
  import bbiow_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire bbiow_apb_t  i_apb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire bbiow_evt_t  i_evt,
  input  wire logic        i_io_valid,
  input  wire logic [31:0] i_io_addr,
  output logic             o_io_forward,
  output logic [7:0]       o_sub_bus,
  output logic             o_irq
);

  logic [7:0]      sub_bus_reg;
  logic [3:0]      io_base_reg;
  logic [3:0]      io_lim_reg;
  logic [31:0]     io_up_reg;
  logic [1:0]      ctrl_reg;
  logic [NEVT-1:0] sts_reg;
  logic [NEVT-1:0] ievt_reg;
  logic [NEVT-1:0] mask_reg;
  logic [31:0]     prdata_reg;
  logic            pready_reg;
  logic            pslverr_reg;
  logic            fwd_reg;
  logic            irq_reg;
  logic [31:0]     rd_next;
  logic            hit_next;
  logic [31:0]     io_lo_addr;
  logic [31:0]     io_hi_addr;
  logic [31:0]     st_word;
  logic            wr_fire;
  logic [NEVT-1:0] evt_raw;
  logic [NEVT-1:0] evt_set;
  logic [NEVT-1:0] st_clr;
  logic [NEVT-1:0] ie_clr;
  logic [31:0]     wmask;

  assign o_prdata     = prdata_reg;
  assign o_pready     = pready_reg;
  assign o_pslverr    = pslverr_reg;
  assign o_io_forward = fwd_reg;
  assign o_sub_bus    = sub_bus_reg;
  assign o_irq        = irq_reg;

  // A write lands only at the edge where the master sees pready high
  assign wr_fire = i_apb.psel & i_apb.penable & pready_reg & i_apb.pwrite;
  assign wmask   = {{8{i_apb.pstrb[3]}}, {8{i_apb.pstrb[2]}},
                    {8{i_apb.pstrb[1]}}, {8{i_apb.pstrb[0]}}};

  assign evt_raw = i_evt;
  always_comb begin
    evt_set = evt_raw;
    evt_set[0] = evt_raw[0] & ctrl_reg[CTRL_PAR];
    evt_set[4] = evt_raw[4] & ctrl_reg[CTRL_SERR];
  end

  // Window edges, with the upper halves from the upper-16 register
  assign io_lo_addr = {io_up_reg[UPL_LSB-1:0], io_base_reg,
                       IO_LO_FILL};
  assign io_hi_addr = {io_up_reg[31:UPL_LSB], io_lim_reg,
                       IO_HI_FILL};

  // Status word for 0x1C; unlisted bits stay zero
  always_comb begin
    st_word = ZERO32;
    st_word[IOB_CAP_LSB +: 4] = IO_CAP;
    st_word[IOB_LSB +: 4]     = io_base_reg;
    st_word[IOL_CAP_LSB +: 4] = IO_CAP;
    st_word[IOL_LSB +: 4]     = io_lim_reg;
    for (int k = 0; k < NEVT; k++) begin
      st_word[ST_POS[k]] = sts_reg[k];
    end
  end

  always_comb begin
    rd_next  = ZERO32;
    hit_next = 1'b1;
    case (i_apb.paddr)
      OFS_BUS: begin
        rd_next[SUB_LSB +: 8] = sub_bus_reg;
        rd_next[LAT_LSB +: 8] = LAT_VAL;
      end
      OFS_IO:   rd_next = st_word;
      OFS_EVT:  rd_next[NEVT-1:0] = ievt_reg;
      OFS_MASK: rd_next[NEVT-1:0] = mask_reg;
      OFS_CTRL: rd_next[1:0] = ctrl_reg;
      OFS_IOUP: rd_next = io_up_reg;
      default:  hit_next = 1'b0;
    endcase
  end

  // One wait state: answer comes in the second access cycle
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= ZERO32;
    end else begin
      pready_reg  <= i_apb.psel & i_apb.penable & ~pready_reg;
      pslverr_reg <= i_apb.psel & i_apb.penable & ~pready_reg & ~hit_next;
      if (i_apb.psel & i_apb.penable & ~pready_reg & ~i_apb.pwrite) begin
        prdata_reg <= rd_next;
      end else begin
        prdata_reg <= ZERO32;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sub_bus_reg <= SUB_RST;
      io_base_reg <= IO_RST;
      io_lim_reg  <= IO_RST;
    end else if (wr_fire && i_apb.paddr == OFS_BUS) begin
      if (i_apb.pstrb[2]) begin
        sub_bus_reg <= i_apb.pwdata[SUB_LSB +: 8];
      end
    end else if (wr_fire && i_apb.paddr == OFS_IO) begin
      if (i_apb.pstrb[0]) begin
        io_base_reg <= i_apb.pwdata[IOB_LSB +: 4];
      end
      if (i_apb.pstrb[1]) begin
        io_lim_reg <= i_apb.pwdata[IOL_LSB +: 4];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      io_up_reg <= ZERO32;
      ctrl_reg  <= CTRL_RST;
      mask_reg  <= EVT_RST;
    end else if (wr_fire) begin
      if (i_apb.paddr == OFS_IOUP) begin
        io_up_reg <= (io_up_reg & ~wmask) | (i_apb.pwdata & wmask);
      end
      if (i_apb.paddr == OFS_CTRL && i_apb.pstrb[0]) begin
        ctrl_reg <= i_apb.pwdata[1:0];
      end
      if (i_apb.paddr == OFS_MASK && i_apb.pstrb[0]) begin
        mask_reg <= i_apb.pwdata[NEVT-1:0];
      end
    end
  end

  // Sticky status and interrupt bits; set is OR-ed after the clear
  generate
    for (genvar g = 0; g < NEVT; g++) begin : g_evt
      assign st_clr[g] = wr_fire && i_apb.paddr == OFS_IO && ST_W1C[g]
                         && i_apb.pstrb[ST_POS[g] / 8]
                         && i_apb.pwdata[ST_POS[g]];
      assign ie_clr[g] = wr_fire && i_apb.paddr == OFS_EVT
                         && i_apb.pstrb[0] && i_apb.pwdata[g];
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          sts_reg[g]  <= 1'b0;
          ievt_reg[g] <= 1'b0;
        end else begin
          sts_reg[g]  <= (sts_reg[g] & ~st_clr[g]) | evt_set[g];
          ievt_reg[g] <= (ievt_reg[g] & ~ie_clr[g]) | evt_set[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(ievt_reg & mask_reg);
    end
  end

  // Window compare is registered so the decision is glitch free
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fwd_reg <= 1'b0;
    end else begin
      fwd_reg <= i_io_valid && i_io_addr >= io_lo_addr
                 && i_io_addr <= io_hi_addr;
    end
  end

  chk_sub_bus_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (wr_fire && i_apb.paddr == OFS_BUS && i_apb.pstrb[2])
    |=> o_sub_bus == $past(i_apb.pwdata[SUB_LSB +: 8]))
    else $error("subordinate bus not written");

  chk_latency_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_apb.psel && i_apb.penable && !pready_reg && !i_apb.pwrite
     && i_apb.paddr == OFS_BUS)
    |=> o_pready && o_prdata[LAT_LSB +: 8] == LAT_VAL)
    else $error("latency timer not zero");

  chk_cap_nibbles: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_apb.psel && i_apb.penable && !pready_reg && !i_apb.pwrite
     && i_apb.paddr == OFS_IO)
    |=> o_prdata[IOB_CAP_LSB +: 4] == IO_CAP
        && o_prdata[IOL_CAP_LSB +: 4] == IO_CAP
        && o_prdata[23] == 1'b0 && o_prdata[21] == 1'b0)
    else $error("io capability or hardwired bits wrong");

  chk_parity_gate: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!ctrl_reg[CTRL_PAR] && !sts_reg[0]) |=> !sts_reg[0])
    else $error("parity bit set while response disabled");

  chk_serr_gate: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_evt.err_msg && ctrl_reg[CTRL_SERR]) |=> sts_reg[4])
    else $error("system error bit not set");

  chk_ro_sticky: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    sts_reg[1] |=> sts_reg[1] [*3])
    else $error("completer abort bit lost");

  chk_set_wins: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_evt.poison && st_clr[5]) |=> sts_reg[5])
    else $error("clear beat a same-cycle event");

  chk_w1c_clear: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_clr[5] && !i_evt.poison) |=> !sts_reg[5])
    else $error("poison bit not cleared");

  chk_fwd_range: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_io_valid |=> o_io_forward == ($past(i_io_addr) >= $past(io_lo_addr)
                   && $past(i_io_addr) <= $past(io_hi_addr)))
    else $error("forward decision wrong");

  chk_abort_rcvd: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_evt.ca_rcvd || i_evt.ur_rcvd)
    |=> (sts_reg[2] || !$past(i_evt.ca_rcvd))
        && (sts_reg[3] || !$past(i_evt.ur_rcvd)))
    else $error("received abort bits not set");

  // Field reads, holds and sticky behaviour

  chk_sub_bus_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_apb.psel && i_apb.penable && !pready_reg && !i_apb.pwrite
     && i_apb.paddr == OFS_BUS)
    |=> o_prdata[SUB_LSB +: 8] == $past(sub_bus_reg))
    else $error("subordinate bus read wrong");

  chk_bus_low_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_apb.psel && i_apb.penable && !pready_reg && !i_apb.pwrite
     && i_apb.paddr == OFS_BUS)
    |=> o_prdata[SUB_LSB-1:0] == 16'h0000)
    else $error("unimplemented bus bytes not zero");

  chk_io_base_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_apb.psel && i_apb.penable && !pready_reg && !i_apb.pwrite
     && i_apb.paddr == OFS_IO)
    |=> o_prdata[IOB_LSB +: 4] == $past(io_base_reg))
    else $error("io base read wrong");

  chk_io_lim_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_apb.psel && i_apb.penable && !pready_reg && !i_apb.pwrite
     && i_apb.paddr == OFS_IO)
    |=> o_prdata[IOL_LSB +: 4] == $past(io_lim_reg))
    else $error("io limit read wrong");

  chk_rsvd_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_apb.psel && i_apb.penable && !pready_reg && !i_apb.pwrite
     && i_apb.paddr == OFS_IO)
    |=> o_prdata[SUB_LSB +: 8] == 8'h00 && o_prdata[26:25] == 2'h0)
    else $error("reserved status bits not zero");

  chk_sub_bus_hold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(wr_fire && i_apb.paddr == OFS_BUS && i_apb.pstrb[2])
    |=> $stable(sub_bus_reg))
    else $error("subordinate bus changed without write");

  chk_io_base_hold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(wr_fire && i_apb.paddr == OFS_IO && i_apb.pstrb[0])
    |=> $stable(io_base_reg))
    else $error("io base changed without write");

  chk_io_lim_hold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !(wr_fire && i_apb.paddr == OFS_IO && i_apb.pstrb[1])
    |=> $stable(io_lim_reg))
    else $error("io limit changed without write");

  chk_ca_sent_set: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_evt.ca_sent |=> sts_reg[1])
    else $error("completer abort sent bit not set");

  chk_poison_set: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_evt.poison |=> sts_reg[5])
    else $error("poison bit not set");

  chk_parity_set: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_evt.parity && ctrl_reg[CTRL_PAR]) |=> sts_reg[0])
    else $error("parity bit not set while enabled");

  chk_serr_block: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!ctrl_reg[CTRL_SERR] && !sts_reg[4]) |=> !sts_reg[4])
    else $error("system error bit set while disabled");

  chk_w1c_parity: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_clr[0] && !evt_set[0]) |=> !sts_reg[0])
    else $error("parity bit not cleared");

  chk_ca_rcvd_keep: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    sts_reg[2] |=> sts_reg[2])
    else $error("completer abort received bit lost");

  chk_ur_rcvd_keep: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    sts_reg[3] |=> sts_reg[3])
    else $error("unsupported request bit lost");

  chk_no_fwd_idle: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_io_valid |=> !o_io_forward)
    else $error("forward without a valid address");

  chk_sts_quiet: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (evt_set == '0 && st_clr == '0) |=> $stable(sts_reg))
    else $error("status changed with no event or clear");

endmodule

// >>> logic/bbiow_pkg.sv
// Package: register map, field layout and carrier types of the bridge regs
package bbiow_pkg;
  localparam logic [7:0]  OFS_BUS      = 8'h18;
  localparam logic [7:0]  OFS_IO       = 8'h1C;
  localparam logic [7:0]  OFS_EVT      = 8'h40;
  localparam logic [7:0]  OFS_MASK     = 8'h44;
  localparam logic [7:0]  OFS_CTRL     = 8'h48;
  localparam logic [7:0]  OFS_IOUP     = 8'h4C;
  localparam int          SUB_LSB      = 16;
  localparam int          LAT_LSB      = 24;
  localparam int          IOB_CAP_LSB  = 0;
  localparam int          IOB_LSB      = 4;
  localparam int          IOL_CAP_LSB  = 8;
  localparam int          IOL_LSB      = 12;
  localparam int          UPL_LSB      = 16;
  localparam int          CTRL_PAR     = 0;
  localparam int          CTRL_SERR    = 1;
  localparam logic [7:0]  SUB_RST      = 8'h00;
  localparam logic [7:0]  LAT_VAL      = 8'h00;
  localparam logic [3:0]  IO_RST       = 4'h0;
  localparam logic [3:0]  IO_CAP       = 4'h1;
  localparam logic [11:0] IO_LO_FILL   = 12'h000;
  localparam logic [11:0] IO_HI_FILL   = 12'hFFF;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;
  localparam int          NEVT         = 6;
  // Status bit positions, in event order
  localparam int          ST_POS [NEVT] = '{24, 27, 28, 29, 30, 31};
  // Which status bits software may clear
  localparam logic [5:0]  ST_W1C       = 6'h31;
  localparam logic [5:0]  EVT_RST      = 6'h00;
  localparam logic [1:0]  CTRL_RST     = 2'h0;

  typedef struct packed {
    logic poison;
    logic err_msg;
    logic ur_rcvd;
    logic ca_rcvd;
    logic ca_sent;
    logic parity;
  } bbiow_evt_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } bbiow_apb_t;
endpackage

// >>> dv/bbiow_host.sv
// APB requester model standing in for the configuration host
module bbiow_host
  import bbiow_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  output bbiow_apb_t       o_apb
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_apb = '0;

  // Holds the request until pready is seen; a dead slave is left to the
  // bench watchdog rather than cut short here
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic err);
    @(posedge i_clk);
    o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
               pwdata: d, pstrb: s};
    @(posedge i_clk);
    o_apb.penable <= 1'b1;
    @(posedge i_clk);
    while (i_pready !== 1'b1) begin
      @(posedge i_clk);
    end
    q = i_prdata;
    err = i_pslverr;
    o_apb <= '0;
  endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the bridge bus, I/O window and status registers
module testbench import bbiow_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk       = 1'b0;
  logic        i_reset_n   = 1'b0;
  bbiow_apb_t  apb;
  bbiow_evt_t  evt         = '0;
  logic        io_valid    = 1'b0;
  logic [31:0] io_addr     = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        io_fwd;
  logic        irq;
  logic [7:0]  sub_bus;
  logic [31:0] q;
  logic        err;
  int          miscompares = 0;
  int          n_checks    = 0;

  always #12.5 i_clk = ~i_clk;

  bbiow_host host (.i_clk(i_clk), .i_prdata(prdata), .i_pready(pready),
                   .i_pslverr(pslverr), .o_apb(apb));

  bbiow_regs dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_apb(apb),
                  .o_prdata(prdata), .o_pready(pready),
                  .o_pslverr(pslverr), .i_evt(evt),
                  .i_io_valid(io_valid), .i_io_addr(io_addr),
                  .o_io_forward(io_fwd), .o_sub_bus(sub_bus),
                  .o_irq(irq));

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    host.xfer(1'b1, a, d, s, q, err);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp, string nm);
    host.xfer(1'b0, a, 32'h0000_0000, 4'h0, q, err);
    chk(nm, q, exp);
  endtask

  // Forward decision shows one cycle after the sampled address
  task automatic io(logic [31:0] a, logic e);
    @(posedge i_clk);
    io_valid <= 1'b1;
    io_addr  <= a;
    @(posedge i_clk);
    io_valid <= 1'b0;
    #1;
    chk("forward", {31'h0, io_fwd}, {31'h0, e});
  endtask

  task automatic pulse(bbiow_evt_t e);
    @(posedge i_clk);
    evt <= e;
    @(posedge i_clk);
    evt <= '0;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    chk("sub_bus rst", {24'h0, sub_bus}, 32'h0);
    rd(OFS_BUS, 32'h0000_0000, "bus rst");
    rd(OFS_IO, 32'h0000_0101, "io rst");
    wr(OFS_BUS, 32'hFFFF_FFFF, 4'hF);
    rd(OFS_BUS, 32'h00FF_0000, "bus wr");
    chk("sub_bus", {24'h0, sub_bus}, 32'h0000_00FF);
    wr(OFS_IO, 32'hFFFF_FFFF, 4'hF);
    rd(OFS_IO, 32'h0000_F1F1, "io wr");
    rd(8'h50, 32'h0000_0000, "unmapped");
    chk("slverr", {31'h0, err}, 32'h1);
    // Window 0x0001_3000 to 0x0001_5FFF, edges probed on both sides
    wr(OFS_IO, 32'h0000_5030, 4'h3);
    wr(OFS_IOUP, 32'h0001_0001, 4'hF);
    io(32'h0001_2FFF, 1'b0);
    io(32'h0001_3000, 1'b1);
    io(32'h0001_5FFF, 1'b1);
    io(32'h0001_6000, 1'b0);
    io(32'h0000_3000, 1'b0);
    io(32'h0002_4000, 1'b0);
    wr(OFS_CTRL, 32'h0000_0000, 4'h1);
    pulse(6'h11);
    rd(OFS_IO, 32'h0000_5131, "gated");
    wr(OFS_CTRL, 32'h0000_0003, 4'h1);
    pulse(6'h3F);
    rd(OFS_IO, 32'hF900_5131, "events");
    rd(OFS_EVT, 32'h0000_003F, "evt stat");
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h0000_0002, 4'h1);
    rd(OFS_MASK, 32'h0000_0002, "mask");
    chk("irq", {31'h0, irq}, 32'h1);
    wr(OFS_EVT, 32'h0000_003F, 4'h1);
    wr(OFS_IO, 32'hFF00_0000, 4'h8);
    rd(OFS_IO, 32'h3800_5131, "w1c");
    rd(OFS_EVT, 32'h0000_0000, "evt clr");
    chk("irq clr", {31'h0, irq}, 32'h0);
    // Poison event lands on the same edge as its clear; the event wins
    fork
      wr(OFS_IO, 32'h8000_0000, 4'h8);
      begin
        repeat (3) @(posedge i_clk);
        evt <= 6'h20;
        @(posedge i_clk);
        evt <= '0;
      end
    join
    rd(OFS_IO, 32'hB800_5131, "set wins");
    // Reset in mid-run must restore the 0x1C and 0x18 fields read back here
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(OFS_IO, 32'h0000_0101, "io rst2");
    rd(OFS_BUS, 32'h0000_0000, "bus rst2");
    print_verdict();
  end

  initial begin
    #50us;
    miscompares++;
    print_verdict();
  end
endmodule
